// *** common/pmt_pkg.sv ***
// Constants for the program memory and table read block
package pmt_pkg;
    // -----------------------------------------------------------------
    // Geometry
    // -----------------------------------------------------------------
    localparam int PMT_AW = 12;
    localparam int PMT_DW = 16;
    localparam int PMT_DEPTH = 4096;
    localparam logic [11:0] PMT_RESET_VECTOR = 12'h000;
    localparam int PMT_HI_BITS = 8;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int PMT_CLK_NS = 40;
    localparam int PMT_LINK_PERIOD_NS = 320;
    localparam int PMT_TABLE_CYCLES = 2;
    // Serial frame: 1 command bit, 12 address bits, 16 data bits
    localparam int PMT_FRAME_BITS = 29;
    localparam logic [4:0] PMT_FRAME_LAST = 5'h1c;
    localparam logic [4:0] PMT_ADDR_LAST = 5'h0c;
    // -----------------------------------------------------------------
    // Sequencer states
    // -----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        PMT_IDLE = 3'b001,
        PMT_READ = 3'b010,
        PMT_DONE = 3'b100
    } pmt_state_e;
endpackage

// *** src/pmt_serial_port.sv ***
// Serial programming and debug port with program store write/read access
`timescale 1ns/1ps
module pmt_serial_port
    import pmt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Synchronised serial pins
    input wire logic data_in,
    input wire logic clock_in,
    input wire logic active,
    // Data pin drive
    output logic data_out,
    output logic data_oe,
    // Program store access
    output logic wr_en,
    output logic [11:0] addr,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    logic clock_q;
    logic [4:0] bit_cnt;
    logic cmd_read;
    logic [15:0] shift_out;
    logic rise;
    logic fall;

    assign rise = clock_in & ~clock_q;
    assign fall = ~clock_in & clock_q;

    // Edge detector on the already synchronised link clock
    always_ff @(posedge clk)
    begin
        if (!rstn)
            clock_q <= 1'b0;
        else
            clock_q <= clock_in;
    end

    // Shift in command, address and data on rising link edges
    always_ff @(posedge clk)
    begin
        if (!rstn || !active)
        begin
            bit_cnt <= 5'h00;
            cmd_read <= 1'b0;
            addr <= 12'h000;
            wdata <= 16'h0000;
            wr_en <= 1'b0;
        end
        else
        begin
            wr_en <= 1'b0;
            if (rise)
            begin
                if (bit_cnt == 5'h00)
                    cmd_read <= data_in;
                else if (bit_cnt <= PMT_ADDR_LAST)
                    addr <= {addr[10:0], data_in};
                else
                    wdata <= {wdata[14:0], data_in};
                // Write fires once all data bits are in
                wr_en <= (bit_cnt == PMT_FRAME_LAST) && !cmd_read;
                bit_cnt <= (bit_cnt == PMT_FRAME_LAST) ? 5'h00 : bit_cnt + 5'h01;
            end
        end
    end

    // Upload: drive data bits out on falling edges during a read frame
    always_ff @(posedge clk)
    begin
        if (!rstn || !active)
        begin
            shift_out <= 16'h0000;
            data_out <= 1'b0;
            data_oe <= 1'b0;
        end
        else if (fall && cmd_read)
        begin
            if (bit_cnt == PMT_ADDR_LAST + 5'h01)
            begin
                data_out <= rdata[15];
                shift_out <= {rdata[14:0], 1'b0};
                data_oe <= 1'b1;
            end
            else if (bit_cnt > PMT_ADDR_LAST + 5'h01)
            begin
                data_out <= shift_out[15];
                shift_out <= {shift_out[14:0], 1'b0};
            end
            else
                data_oe <= 1'b0;
        end
        else if (fall)
            data_oe <= 1'b0;
    end
endmodule

// *** src/pmt_program_memory.sv ***
// Program store, reset vector, table read path and serial programming pins
`timescale 1ns/1ps
module pmt_program_memory
    import pmt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Instruction fetch
    input wire logic pc_load,
    input wire logic [11:0] pc_load_value,
    input wire logic pc_advance,
    output logic [11:0] pc,
    output logic [15:0] fetch_word,
    // Table read request
    input wire logic table_read_op,
    input wire logic [7:0] table_ptr_low,
    input wire logic [7:0] table_ptr_high,
    input wire logic [7:0] operand_addr,
    output logic table_busy,
    output logic dm_we,
    output logic [7:0] dm_addr,
    output logic [7:0] dm_wdata,
    output logic [7:0] table_high_byte_latch,
    // Mode selects
    input wire logic in_circuit_programming,
    input wire logic on_chip_debug,
    // Port A normal function
    input wire logic port_a_bit0_out,
    input wire logic port_a_bit0_oe,
    input wire logic port_a_bit2_out,
    input wire logic port_a_bit2_oe,
    output logic port_a_bit0_in,
    output logic port_a_bit2_in,
    // Shared pins, programming and debug
    input wire logic prog_serial_data_in,
    output logic prog_serial_data_out,
    output logic prog_serial_data_oe,
    input wire logic prog_serial_clock_in,
    output logic prog_serial_clock_out,
    output logic prog_serial_clock_oe,
    // Serial tool access is active
    output logic serial_active
);
    // -----------------------------------------------------------------
    // Storage and state
    // -----------------------------------------------------------------
    logic [15:0] mem [0:PMT_DEPTH-1];
    pmt_state_e state;
    logic [11:0] tab_addr;
    logic [15:0] tab_word;
    logic [7:0] op_q;
    logic data_s1;
    logic data_s2;
    logic clk_s1;
    logic clk_s2;
    logic mode;
    logic ser_we;
    logic [11:0] ser_addr;
    logic [15:0] ser_wdata;
    logic [15:0] ser_rdata;
    logic ser_out;
    logic ser_oe;

    // Either mode claims the pins; debug pins double as programming pins
    assign mode = in_circuit_programming | on_chip_debug;

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            data_s1 <= 1'b0;
            data_s2 <= 1'b0;
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
        end
        else
        begin
            data_s1 <= prog_serial_data_in;
            data_s2 <= data_s1;
            clk_s1 <= prog_serial_clock_in;
            clk_s2 <= clk_s1;
        end
    end

    // -----------------------------------------------------------------
    // Program counter and fetch
    // -----------------------------------------------------------------
    // Reset vector, then sequential or loaded; tool mode holds the counter at the vector
    always_ff @(posedge clk)
    begin
        if (!rstn)
            pc <= PMT_RESET_VECTOR;
        else if (mode)
            pc <= PMT_RESET_VECTOR;
        else if (pc_load)
            pc <= pc_load_value;
        else if (pc_advance && !table_busy)
            pc <= pc + 12'h001;
    end

    // Synchronous store; one write port, reads for fetch, table and tool
    always_ff @(posedge clk)
    begin
        if (ser_we)
            mem[ser_addr] <= ser_wdata;
        fetch_word <= mem[pc];
        tab_word <= mem[tab_addr];
        ser_rdata <= mem[ser_addr];
    end

    // -----------------------------------------------------------------
    // Table read sequencer
    // -----------------------------------------------------------------
    // Pointer only, program counter plays no part
    assign tab_addr = {table_ptr_high[3:0], table_ptr_low};

    // Two cycles: read word, then deliver both bytes
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state <= PMT_IDLE;
            op_q <= 8'h00;
        end
        else
        begin
            case (state)
                PMT_IDLE:
                begin
                    if (table_read_op && !mode)
                    begin
                        state <= PMT_READ;
                        op_q <= operand_addr;
                    end
                end
                PMT_READ: state <= PMT_DONE;
                PMT_DONE: state <= PMT_IDLE;
                default: state <= PMT_IDLE;
            endcase
        end
    end

    // Busy covers the read cycle so the core holds its fetch
    always_ff @(posedge clk)
    begin
        if (!rstn)
            table_busy <= 1'b0;
        else
            table_busy <= (state == PMT_IDLE) && table_read_op && !mode;
    end

    // Low byte to data memory, high byte to read-only latch
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            dm_we <= 1'b0;
            dm_addr <= 8'h00;
            dm_wdata <= 8'h00;
            table_high_byte_latch <= 8'h00;
        end
        else
        begin
            dm_we <= (state == PMT_READ);
            if (state == PMT_READ)
            begin
                dm_addr <= op_q;
                dm_wdata <= tab_word[7:0];
                // No write path exists; all eight upper word bits are latched
                table_high_byte_latch <= tab_word[15:8];
            end
        end
    end

    // -----------------------------------------------------------------
    // Serial tool port and pin muxing
    // -----------------------------------------------------------------
    pmt_serial_port u_serial
    (
        .clk(clk),
        .rstn(rstn),
        .data_in(data_s2),
        .clock_in(clk_s2),
        .active(mode),
        .data_out(ser_out),
        .data_oe(ser_oe),
        .wr_en(ser_we),
        .addr(ser_addr),
        .wdata(ser_wdata),
        .rdata(ser_rdata)
    );

    // Registered pin drive; port functions masked while tool owns pins
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            prog_serial_data_out <= 1'b0;
            prog_serial_data_oe <= 1'b0;
            prog_serial_clock_out <= 1'b0;
            prog_serial_clock_oe <= 1'b0;
            port_a_bit0_in <= 1'b0;
            port_a_bit2_in <= 1'b0;
            serial_active <= 1'b0;
        end
        else
        begin
            serial_active <= mode;
            prog_serial_data_out <= mode ? ser_out : port_a_bit0_out;
            prog_serial_data_oe <= mode ? ser_oe : port_a_bit0_oe;
            prog_serial_clock_out <= mode ? 1'b0 : port_a_bit2_out;
            prog_serial_clock_oe <= mode ? 1'b0 : port_a_bit2_oe;
            port_a_bit0_in <= mode ? 1'b0 : data_s2;
            port_a_bit2_in <= mode ? 1'b0 : clk_s2;
        end
    end
endmodule

// *** tb/pmt_program_memory_asserts.sv ***
// Checker for the table read path and tool-mode pin ownership
`timescale 1ns/1ps
module pmt_program_memory_asserts
    import pmt_pkg::*;
(
    // Clock, reset and requests
    input wire logic clk,
    input wire logic rstn,
    input wire logic table_read_op,
    input wire logic [7:0] operand_addr,
    input wire logic in_circuit_programming,
    input wire logic on_chip_debug,
    // Observed outputs
    input wire logic table_busy,
    input wire logic dm_we,
    input wire logic [7:0] dm_addr,
    input wire logic [7:0] dm_wdata,
    input wire logic [7:0] table_high_byte_latch,
    input wire logic [11:0] pc,
    input wire logic port_a_bit0_in,
    input wire logic port_a_bit2_in,
    input wire logic prog_serial_clock_oe,
    input wire logic serial_active
);
    logic rst_d;
    logic take;
    // Past values straight out of reset are stale, so skip that edge
    always_ff @(posedge clk)
    begin
        rst_d <= rstn;
    end
    // A request the block must accept; the mode inputs decide, the registered flag lags
    assign take = table_read_op && !table_busy && !dm_we
        && !in_circuit_programming && !on_chip_debug;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || !rst_d);

    a_read_two_cycles: assert property (take |=>
        table_busy ##1 (dm_we && !table_busy) ##1 !dm_we)
        else $error("table read did not complete in two cycles");
    a_busy_has_cause: assert property ($rose(table_busy) |-> $past(take))
        else $error("busy raised without an accepted request");
    a_tool_refuses: assert property (
        (in_circuit_programming || on_chip_debug) && table_read_op |=> !table_busy)
        else $error("table read accepted in tool mode");
    a_target_reg: assert property (dm_we |-> dm_addr == $past(operand_addr, 2))
        else $error("low byte sent to wrong data register");
    a_latch_readonly: assert property (!dm_we |-> $stable(table_high_byte_latch))
        else $error("high byte latch changed outside a table read");
    a_data_hold: assert property (!dm_we |-> $stable(dm_wdata) && $stable(dm_addr))
        else $error("table data changed outside a table read");
    a_pc_vector: assert property (disable iff (1'b0)
        !rstn |=> pc == PMT_RESET_VECTOR && !dm_we)
        else $error("reset did not load the start vector");
    a_tool_pins: assert property (serial_active |->
        !port_a_bit0_in && !port_a_bit2_in && !prog_serial_clock_oe)
        else $error("shared pins not handed to the tool");

    c_take: cover property (take);
    c_tool_req: cover property (serial_active && table_read_op);
    c_tool_exit: cover property ($fell(serial_active));
endmodule

bind pmt_program_memory pmt_program_memory_asserts chk (.clk, .rstn, .table_read_op, .operand_addr,
    .in_circuit_programming, .on_chip_debug, .table_busy, .dm_we, .dm_addr, .dm_wdata,
    .table_high_byte_latch, .pc, .port_a_bit0_in, .port_a_bit2_in, .prog_serial_clock_oe,
    .serial_active);

// *** tb/pmt_prog_tool.sv ***
// Programmer model: makes the link clock and shares the data line
`timescale 1ns/1ps
module pmt_prog_tool
(
    // Link pins
    input wire logic sda,
    output logic sck,
    output logic sdo,
    output logic sdo_oe
);
    initial
    begin
        sck = 1'b0;
        sdo = 1'b0;
        sdo_oe = 1'b0;
    end
    // One frame MSB first; clock rests low between frames
    task automatic frame(input logic rd, input logic [11:0] a, input logic [15:0] d,
        input int half, output logic [15:0] q);
        logic [28:0] bits;
        bits = {rd, a, d};
        q = '0;
        for (int i = 28; i >= 0; i--)
        begin
            sdo_oe = !rd || i > 15; // Let go before the device answers
            sdo = bits[i];
            #(half);
            sck = 1'b1;
            q = {q[14:0], sda};
            #(half);
            sck = 1'b0;
        end
        sdo_oe = 1'b0;
    endtask
endmodule

// *** tb/tb_program_memory_table_read.sv ***
// Self-checking bench for the program store and table read path
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_program_memory_table_read;
    import pmt_pkg::*;
    typedef struct packed {logic [3:0] junk; logic [11:0] a; logic [15:0] w;
        logic [7:0] op;} pmt_row_s;
    logic clk, rstn, pc_load, pc_advance, table_read_op, in_circuit_programming, on_chip_debug;
    logic port_a_bit0_out, port_a_bit0_oe, port_a_bit2_out, port_a_bit2_oe;
    logic float_v = 1'b0;
    logic [11:0] pc_load_value, pc;
    logic [15:0] fetch_word, q;
    logic [7:0] table_ptr_low, table_ptr_high, operand_addr;
    logic [7:0] dm_addr, dm_wdata, table_high_byte_latch;
    logic table_busy, dm_we, port_a_bit0_in, port_a_bit2_in, serial_active, sck, t_sdo, t_oe;
    logic prog_serial_data_out, prog_serial_data_oe, prog_serial_clock_out, prog_serial_clock_oe;
    wire logic prog_serial_data_in, prog_serial_clock_in;
    int num_checks = 0;
    int bad_count = 0;
    int cycles = 0;
    // Junk pointer bits, address, stored word, target register
    pmt_row_s rows [4] = '{'{4'hf, 12'h000, 16'h1234, 8'h10}, '{4'h0, 12'hf06, 16'h001a, 8'h21},
        '{4'ha, 12'hfff, 16'hbeef, 8'hff}, '{4'h5, 12'h5a3, 16'hc3a5, 8'h00}};

    pmt_program_memory dut (.clk, .rstn, .pc_load, .pc_load_value, .pc_advance, .pc, .fetch_word,
        .table_read_op, .table_ptr_low, .table_ptr_high, .operand_addr, .table_busy, .dm_we,
        .dm_addr, .dm_wdata, .table_high_byte_latch, .in_circuit_programming, .on_chip_debug,
        .port_a_bit0_out, .port_a_bit0_oe, .port_a_bit2_out, .port_a_bit2_oe, .port_a_bit0_in,
        .port_a_bit2_in, .prog_serial_data_in, .prog_serial_data_out, .prog_serial_data_oe,
        .prog_serial_clock_in, .prog_serial_clock_out, .prog_serial_clock_oe, .serial_active);
    pmt_prog_tool tool (.sda(prog_serial_data_in), .sck(sck), .sdo(t_sdo), .sdo_oe(t_oe));

    // Undriven line toggles so a stale value never looks valid
    assign prog_serial_data_in = prog_serial_data_oe ? prog_serial_data_out
        : t_oe ? t_sdo : float_v;
    assign prog_serial_clock_in = prog_serial_clock_oe ? prog_serial_clock_out : sck;
    always #20 clk = ~clk;
    // Cut a hang short
    always @(posedge clk)
    begin
        float_v <= ~float_v;
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One table read, answered two edges after it is taken
    task automatic tread(pmt_row_s r);
        table_ptr_high = {r.junk, r.a[11:8]};
        table_ptr_low = r.a[7:0];
        operand_addr = r.op;
        table_read_op = 1'b1;
        tick(1);
        table_read_op = 1'b0;
        `CHK(table_busy, 1'b1)
        tick(1);
        `CHK(dm_we, 1'b1)
        `CHK({table_high_byte_latch, dm_wdata}, r.w)
        `CHK(dm_addr, r.op)
        tick(1);
        `CHK(dm_we, 1'b0)
    endtask

    initial
    begin
        {clk, rstn, pc_load, pc_advance, table_read_op} = '0;
        {in_circuit_programming, on_chip_debug} = '0;
        {port_a_bit0_out, port_a_bit0_oe, port_a_bit2_out, port_a_bit2_oe} = '0;
        {pc_load_value, table_ptr_low, table_ptr_high, operand_addr} = '0;
        tick(3);
        rstn = 1'b1;
        `CHK(pc, PMT_RESET_VECTOR)
        {port_a_bit0_oe, port_a_bit0_out, port_a_bit2_oe, port_a_bit2_out} = 4'hf;
        tick(4);
        `CHK(prog_serial_data_oe, 1'b1)
        `CHK(prog_serial_data_out, 1'b1)
        `CHK(port_a_bit0_in, 1'b1)
        `CHK(prog_serial_clock_oe, 1'b1)
        `CHK(prog_serial_clock_out, 1'b1)
        `CHK(port_a_bit2_in, 1'b1)
        // Tool mode must take the pins even with the port still driving
        in_circuit_programming = 1'b1;
        tick(4);
        `CHK(prog_serial_data_oe, 1'b0)
        `CHK(port_a_bit0_in, 1'b0)
        `CHK(prog_serial_clock_oe, 1'b0)
        `CHK(prog_serial_clock_out, 1'b0)
        table_read_op = 1'b1;
        tick(2);
        table_read_op = 1'b0;
        `CHK(table_busy, 1'b0)
        foreach (rows[i])
        begin
            tool.frame(1'b0, rows[i].a, rows[i].w, 160, q);
            tick(4);
        end
        // Read back over the shared line
        tool.frame(1'b1, rows[2].a, 16'h0000, 160, q);
        tick(4);
        `CHK(q, rows[2].w)
        in_circuit_programming = 1'b0;
        on_chip_debug = 1'b1;
        tick(4);
        tool.frame(1'b0, 12'h800, 16'h5aa5, 160, q);
        tick(4);
        // Link clock is high mid-frame, yet must not reach the port input
        fork
            tool.frame(1'b1, 12'h800, 16'h0000, 160, q);
            begin
                tick(7);
                `CHK(port_a_bit2_in, 1'b0)
            end
        join
        tick(4);
        `CHK(q, 16'h5aa5)
        `CHK(port_a_bit2_in, 1'b0)
        on_chip_debug = 1'b0;
        tick(4);
        `CHK(port_a_bit2_in, 1'b1)
        // Rows run back to back, three cycles apart
        foreach (rows[i])
            tread(rows[i]);
        // Request held through busy is taken only once
        table_read_op = 1'b1;
        tick(2);
        `CHK(dm_we, 1'b1)
        tick(1);
        table_read_op = 1'b0;
        `CHK(table_busy, 1'b0)
        tick(1);
        `CHK(dm_we, 1'b0)
        pc_load_value = rows[1].a;
        pc_load = 1'b1;
        tick(1);
        pc_load = 1'b0;
        tick(1);
        `CHK(fetch_word, rows[1].w)
        pc_advance = 1'b1;
        tick(1);
        pc_advance = 1'b0;
        `CHK(pc, 12'hf07)
        // Second reset mid-run returns fetch to the vector
        rstn = 1'b0;
        tick(3);
        rstn = 1'b1;
        tick(1);
        `CHK(pc, PMT_RESET_VECTOR)
        `CHK(fetch_word, rows[0].w)
        give_verdict();
    end
endmodule
